// File: reset_cause_defines.svh
`ifndef RESET_CAUSE_DEFINES_SVH
`define RESET_CAUSE_DEFINES_SVH

`define RESET_VECTOR      21'h000000
`define HIGH_IRQ_VECTOR   21'h000008
`define LOW_IRQ_VECTOR    21'h000018
`define PC_WAKE_STEP      21'h000002
`define SOFT_BOR_CFG      2'h1
`define BIT_IRQ_PRIORITY_ENABLE          7
`define BIT_SOFT_BROWNOUT_ENABLE        6
`define BIT_RI            4
`define BIT_TO            3
`define BIT_PD            2
`define BIT_POR           1
`define BIT_BOR           0
`define NUM_EVENTS        8
`define SYNC_STAGES       2
`define FLAGS_RESET_VALUE 9'h0f0

`endif

// File: reset_cause_pkg.sv
package reset_cause_pkg;
  typedef struct packed {
    logic power_on;
    logic brownout;
    logic reset_instr;
    logic ext_pin;
    logic watchdog;
    logic stack_full;
    logic stack_underflow;
    logic irq_wake;
  } event_t;
  typedef enum logic [2:0] {
    MODE_FULL = 3'b001,
    MODE_RUN  = 3'b010,
    MODE_IDLE = 3'b100
  } power_mode_t;
  typedef struct packed {
    logic irq_priority_enable;
    logic soft_brownout_enable;
    logic reset_instr_flag;
    logic watchdog_timeout_flag;
    logic power_down_flag;
    logic power_on_flag;
    logic brownout_flag;
    logic stack_full_flag;
    logic stack_underflow_flag;
  } flags_t;
endpackage

// File: event_sync.sv
`timescale 1ns/10ps
`include "reset_cause_defines.svh"
module event_sync
  import reset_cause_pkg::*;
(
  input  wire logic                     clock_i,
  input  wire logic                     sys_rst_i,
  input  wire logic [`NUM_EVENTS-1:0]   async_i,
  output logic      [`NUM_EVENTS-1:0]   pulse_o
);
  // ----------------------------------------
  // Two-stage synchroniser, then edge detect on stage two only.
  // ----------------------------------------
  logic [`NUM_EVENTS-1:0] s1_r;
  logic [`NUM_EVENTS-1:0] s2_r;
  logic [`NUM_EVENTS-1:0] s3_r;
  logic [`NUM_EVENTS-1:0] s1_nxt;
  logic [`NUM_EVENTS-1:0] s2_nxt;
  logic [`NUM_EVENTS-1:0] s3_nxt;

  genvar g;
  generate
    for (g = 0; g < `NUM_EVENTS; g++)
    begin : gen_bit
      always_comb
      begin
        s1_nxt[g] = async_i[g];
        s2_nxt[g] = s1_r[g];
        s3_nxt[g] = s2_r[g];
      end
    end
  endgenerate

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  assign pulse_o = s2_r & ~s3_r;
endmodule

// File: reset_cause_flags.sv
`timescale 1ns/10ps
`include "reset_cause_defines.svh"
// Contract
// [RL1] Plain registers come up unknown at power-on, kept on other resets.
// [RL2] Watchdog wake resumes operation; registers keep contents.
// [RL3] Power-on: PC 0; set sbor, ri, to, pd; clear por, bor, stack flags.
// [RL4] Reset instruction: PC 0, clear ri, all else unchanged.
// [RL5] Brown-out: PC 0, set ri, to, pd, clear bor; others unchanged.
// [RL6] Pin reset in run mode: PC 0, set to.
// [RL7] Pin reset in idle or sleep: PC 0, set to, clear pd.
// [RL8] Watchdog timeout in full or run mode: PC 0, clear to.
// [RL9] Pin reset in full power: PC 0, flags unchanged.
// [RL10] Stack full with fault reset on: PC 0, set stack full flag.
// [RL11] Stack underflow with fault reset on: PC 0, set underflow flag.
// [RL12] Stack underflow with fault reset off: set underflow flag, no reset.
// [RL13] Watchdog in idle or sleep: wake at PC+2, clear to and pd.
// [RL14] Interrupt wake from power-managed mode: PC+2, clear pd.
// [RL15] Interrupt wake with an enable set loads vector 008h or 0018h.
// [RL16] Soft brown-out enable is 1 at power-on, kept only if cfg 01 and set.
// [RL17] Reset-cause flags are readable status outputs.
// [RL18] Control byte: irq_priority_enable 7, sbor 6, zero 5, ri to pd por bor 4..0.
// [RL19] Software rewrites por and bor to one after reading the causes.
module reset_cause_flags
  import reset_cause_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  input  wire logic              power_on_i,
  input  wire logic              brownout_i,
  input  wire logic              reset_instr_i,
  input  wire logic              external_reset_pin_i,
  input  wire logic              watchdog_i,
  input  wire logic              stack_full_i,
  input  wire logic              stack_underflow_i,
  input  wire logic              irq_wake_i,
  input  wire power_mode_t       power_mode_i,
  input  wire logic              stack_fault_reset_enable_i,
  input  wire logic [1:0]        brownout_mode_cfg_i,
  input  wire logic              high_priority_irq_enable_i,
  input  wire logic              low_priority_irq_enable_i,
  input  wire logic [20:0]       current_pc_i,
  input  wire logic              sw_write_i,
  input  wire logic [7:0]        sw_wdata_i,
  output logic [7:0]             reset_control_status_reg_o,
  output logic                   stack_full_flag_o,
  output logic                   stack_underflow_flag_o,
  output logic [20:0]            restart_pc_o,
  output logic                   restart_valid_o,
  output logic                   core_reset_o
);
  // ----------------------------------------
  // Event synchronisation
  // ----------------------------------------
  logic [`NUM_EVENTS-1:0] ev_raw;
  logic [`NUM_EVENTS-1:0] ev_pulse;
  event_t                 ev;

  assign ev_raw = {power_on_i, brownout_i, reset_instr_i, external_reset_pin_i,
                   watchdog_i, stack_full_i, stack_underflow_i, irq_wake_i};

  event_sync event_sync_inst
  (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (ev_raw),
    .pulse_o   (ev_pulse)
  );

  assign ev = event_t'(ev_pulse);

  // ----------------------------------------
  // Flag state
  // ----------------------------------------
  // Flags start at the power-on values; every register in this block loads a
  // value on sys_rst_i, so none is left unknown here. [RL1]
  flags_t      fl_r;
  flags_t      fl_nxt;
  logic [20:0] pc_r;
  logic [20:0] pc_nxt;
  logic        valid_r;
  logic        valid_nxt;
  logic        crst_r;
  logic        crst_nxt;
  logic        sbor_keep;

  assign sbor_keep = (brownout_mode_cfg_i == `SOFT_BOR_CFG) && fl_r.soft_brownout_enable;

  always_comb
  begin
    fl_nxt    = fl_r;
    pc_nxt    = pc_r;
    valid_nxt = 1'b0;
    crst_nxt  = 1'b0;
    // Software write comes first so any hardware event in the same cycle wins.
    if (sw_write_i)
    begin
      fl_nxt.irq_priority_enable   = sw_wdata_i[`BIT_IRQ_PRIORITY_ENABLE];
      fl_nxt.soft_brownout_enable  = sw_wdata_i[`BIT_SOFT_BROWNOUT_ENABLE];
      fl_nxt.reset_instr_flag      = sw_wdata_i[`BIT_RI];
      fl_nxt.power_on_flag         = sw_wdata_i[`BIT_POR];   // [RL19]
      fl_nxt.brownout_flag         = sw_wdata_i[`BIT_BOR];   // [RL19]
    end
    if (ev.power_on)
    begin
      pc_nxt = `RESET_VECTOR;
      valid_nxt = 1'b1;
      crst_nxt  = 1'b1;
      fl_nxt.soft_brownout_enable  = 1'b1;                    // [RL16]
      fl_nxt.reset_instr_flag      = 1'b1;                    // [RL3]
      fl_nxt.watchdog_timeout_flag = 1'b1;
      fl_nxt.power_down_flag       = 1'b1;
      fl_nxt.power_on_flag         = 1'b0;
      fl_nxt.brownout_flag         = 1'b0;
      fl_nxt.stack_full_flag       = 1'b0;
      fl_nxt.stack_underflow_flag  = 1'b0;
      fl_nxt.irq_priority_enable   = 1'b0;
    end
    else if (ev.brownout || ev.reset_instr || ev.ext_pin ||
             (ev.watchdog && power_mode_i != MODE_IDLE) ||
             (stack_fault_reset_enable_i && (ev.stack_full || ev.stack_underflow)))
    begin
      pc_nxt    = `RESET_VECTOR;
      valid_nxt = 1'b1;
      crst_nxt  = 1'b1;
      fl_nxt.soft_brownout_enable = sbor_keep;                // [RL16]
      fl_nxt.irq_priority_enable  = 1'b0;
      if (ev.brownout)
      begin
        fl_nxt.reset_instr_flag      = 1'b1;                  // [RL5]
        fl_nxt.watchdog_timeout_flag = 1'b1;
        fl_nxt.power_down_flag       = 1'b1;
        fl_nxt.brownout_flag         = 1'b0;
      end
      else if (ev.reset_instr)
        fl_nxt.reset_instr_flag = 1'b0;                       // [RL4]
      else if (ev.ext_pin)
      begin
        unique case (power_mode_i)
          MODE_FULL: ;                                        // [RL9]
          MODE_RUN:  fl_nxt.watchdog_timeout_flag = 1'b1;     // [RL6]
          MODE_IDLE:
          begin
            fl_nxt.watchdog_timeout_flag = 1'b1;              // [RL7]
            fl_nxt.power_down_flag       = 1'b0;
          end
          default: ;
        endcase
      end
      else if (ev.watchdog)
        fl_nxt.watchdog_timeout_flag = 1'b0;                  // [RL8]
      else if (ev.stack_full)
        fl_nxt.stack_full_flag = 1'b1;                        // [RL10]
      else
        fl_nxt.stack_underflow_flag = 1'b1;                   // [RL11]
    end
    else if (ev.watchdog)
    begin
      // Wake only; nothing else is reset. [RL2]
      pc_nxt    = current_pc_i + `PC_WAKE_STEP;               // [RL13]
      valid_nxt = 1'b1;
      fl_nxt.watchdog_timeout_flag = 1'b0;
      fl_nxt.power_down_flag       = 1'b0;
    end
    else
    begin
      if (ev.irq_wake && power_mode_i != MODE_FULL)
      begin
        valid_nxt = 1'b1;
        fl_nxt.power_down_flag = 1'b0;                        // [RL14]
        if (high_priority_irq_enable_i)
          pc_nxt = `HIGH_IRQ_VECTOR;                          // [RL15]
        else if (low_priority_irq_enable_i)
          pc_nxt = `LOW_IRQ_VECTOR;                           // [RL15]
        else
          pc_nxt = current_pc_i + `PC_WAKE_STEP;              // [RL14]
      end
    end
    // An underflow with the fault reset off is only an error, so it must not be
    // lost behind a wake or a reset other than power-on that arrives in the same cycle.
    if (ev.stack_underflow && !stack_fault_reset_enable_i && !ev.power_on)
      fl_nxt.stack_underflow_flag = 1'b1;                     // [RL12]
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      fl_r    <= flags_t'(`FLAGS_RESET_VALUE);
      pc_r    <= `RESET_VECTOR;
      valid_r <= 1'b0;
      crst_r  <= 1'b0;
    end
    else
    begin
      fl_r    <= fl_nxt;
      pc_r    <= pc_nxt;
      valid_r <= valid_nxt;
      crst_r  <= crst_nxt;
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  // Bit 5 is unimplemented and reads as zero. [RL18]
  assign reset_control_status_reg_o = {fl_r.irq_priority_enable, fl_r.soft_brownout_enable,
                                       1'b0, fl_r.reset_instr_flag, fl_r.watchdog_timeout_flag,
                                       fl_r.power_down_flag, fl_r.power_on_flag,
                                       fl_r.brownout_flag};   // [RL17]
  assign stack_full_flag_o      = fl_r.stack_full_flag;
  assign stack_underflow_flag_o = fl_r.stack_underflow_flag;
  assign restart_pc_o           = pc_r;
  assign restart_valid_o        = valid_r;
  assign core_reset_o           = crst_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_por_flags: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL3]
    ev.power_on |=> reset_control_status_reg_o[4:0] == 5'h1c && !stack_full_flag_o
                    && restart_pc_o == `RESET_VECTOR && core_reset_o)
    else $error("power-on flags wrong");
  chk_ri_clear: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL4]
    ev.reset_instr && !ev.power_on && !ev.brownout |=> !reset_control_status_reg_o[`BIT_RI])
    else $error("reset instruction flag not cleared");
  chk_bor_flags: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL5]
    ev.brownout && !ev.power_on |=> reset_control_status_reg_o[4:2] == 3'h7
                    && !reset_control_status_reg_o[`BIT_BOR]
                    && $stable(reset_control_status_reg_o[`BIT_POR]))
    else $error("brown-out flags wrong");
  chk_wdt_wake: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL13]
    ev.watchdog && power_mode_i == MODE_IDLE && ev_pulse[7:4] == 4'h0 && !(ev.stack_full
    && stack_fault_reset_enable_i) && !(ev.stack_underflow && stack_fault_reset_enable_i)
    |=> restart_pc_o == $past(current_pc_i) + `PC_WAKE_STEP && !core_reset_o
        && reset_control_status_reg_o[3:2] == 2'h0)
    else $error("watchdog wake wrong");
  chk_irq_vector: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL15]
    ev_pulse[7:3] == 5'h0 && !(ev.stack_full && stack_fault_reset_enable_i)
    && !(ev.stack_underflow && stack_fault_reset_enable_i) && ev.irq_wake
    && power_mode_i != MODE_FULL && high_priority_irq_enable_i
    |=> restart_pc_o == `HIGH_IRQ_VECTOR && !reset_control_status_reg_o[`BIT_PD])
    else $error("interrupt vector wrong");
  chk_unf_flag: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL12]
    ev.stack_underflow && !ev.power_on
    && (!stack_fault_reset_enable_i || ev_pulse[7:2] == 6'h0) |=> stack_underflow_flag_o)
    else $error("underflow flag not set");
  chk_sbor_clear: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL16]
    !ev.power_on && ev.brownout && brownout_mode_cfg_i != `SOFT_BOR_CFG
    |=> !reset_control_status_reg_o[`BIT_SOFT_BROWNOUT_ENABLE])
    else $error("soft brown-out enable kept");
  chk_bit5_zero: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL18]
    !reset_control_status_reg_o[5])
    else $error("bit 5 not zero");

  // ----------------------------------------
  // Checks of the pin, watchdog, stack and wake cases
  // ----------------------------------------
  // Each antecedent shuts out the events of higher priority, so that a check
  // only speaks for the case that actually wins the cycle.
  chk_pin_idle: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL7]
    ev.ext_pin && ev_pulse[7:5] == 3'h0 && power_mode_i == MODE_IDLE
    |=> reset_control_status_reg_o[3:2] == 2'h2 && core_reset_o
        && restart_pc_o == `RESET_VECTOR)
    else $error("pin reset in idle flags wrong");
  chk_pin_run: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL6]
    ev.ext_pin && ev_pulse[7:5] == 3'h0 && power_mode_i == MODE_RUN
    |=> reset_control_status_reg_o[`BIT_TO] && $stable(reset_control_status_reg_o[`BIT_PD])
        && core_reset_o)
    else $error("pin reset in run flags wrong");
  chk_pin_full: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL9]
    ev.ext_pin && ev_pulse[7:5] == 3'h0 && power_mode_i == MODE_FULL
    |=> $stable(reset_control_status_reg_o[3:2]) && core_reset_o
        && restart_pc_o == `RESET_VECTOR)
    else $error("pin reset in full power changed flags");
  chk_wdt_reset: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL8]
    ev.watchdog && ev_pulse[7:4] == 4'h0 && power_mode_i != MODE_IDLE
    |=> !reset_control_status_reg_o[`BIT_TO] && core_reset_o
        && restart_pc_o == `RESET_VECTOR)
    else $error("watchdog reset flags wrong");
  chk_wake_keeps: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL2]
    ev.watchdog && power_mode_i == MODE_IDLE && ev_pulse[7:4] == 4'h0 && !sw_write_i
    && !((ev.stack_full || ev.stack_underflow) && stack_fault_reset_enable_i)
    |=> $stable(reset_control_status_reg_o[7:4]) && $stable(reset_control_status_reg_o[1:0]))
    else $error("watchdog wake changed other flags");
  chk_full_flag: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL10]
    ev.stack_full && stack_fault_reset_enable_i && ev_pulse[7:3] == 5'h0
    |=> stack_full_flag_o && core_reset_o && restart_pc_o == `RESET_VECTOR)
    else $error("stack full reset wrong");
  chk_unf_reset: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL11]
    ev.stack_underflow && stack_fault_reset_enable_i && ev_pulse[7:2] == 6'h0
    |=> stack_underflow_flag_o && core_reset_o && restart_pc_o == `RESET_VECTOR)
    else $error("stack underflow reset wrong");
  chk_irq_resume: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL14]
    ev_pulse[7:3] == 5'h0 && ev.irq_wake && power_mode_i != MODE_FULL
    && !((ev.stack_full || ev.stack_underflow) && stack_fault_reset_enable_i)
    && !high_priority_irq_enable_i && !low_priority_irq_enable_i
    |=> restart_pc_o == $past(current_pc_i) + `PC_WAKE_STEP && restart_valid_o
        && !core_reset_o && !reset_control_status_reg_o[`BIT_PD])
    else $error("interrupt resume wrong");
  chk_irq_low: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL15]
    ev_pulse[7:3] == 5'h0 && ev.irq_wake && power_mode_i != MODE_FULL
    && !((ev.stack_full || ev.stack_underflow) && stack_fault_reset_enable_i)
    && !high_priority_irq_enable_i && low_priority_irq_enable_i
    |=> restart_pc_o == `LOW_IRQ_VECTOR && restart_valid_o && !core_reset_o)
    else $error("low interrupt vector wrong");
  chk_irq_full: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL14]
    ev_pulse[7:1] == 7'h0 && ev.irq_wake && power_mode_i == MODE_FULL
    |=> !restart_valid_o && $stable(restart_pc_o))
    else $error("interrupt in full power not ignored");
endmodule

// File: reset_cause_flags_tb.sv
`timescale 1ns/10ps
module reset_cause_flags_tb;
  import reset_cause_pkg::*;

  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  // The whole run needs about 1500 cycles, so this ceiling only trips on a hang.
  localparam int LIMIT = 4000;
  logic        clock_i    = 1'b0;
  logic        sys_rst_i  = 1'b1;
  logic [7:0]  ev_r       = 8'h00;
  power_mode_t mode_r     = MODE_FULL;
  logic        stk_en_r   = 1'b1;
  logic [1:0]  cfg_r      = 2'h1;
  logic        hi_r       = 1'b0;
  logic        lo_r       = 1'b0;
  logic [20:0] pc_r       = 21'h000000;
  logic        wr_r       = 1'b0;
  logic [7:0]  wd_r       = 8'h00;
  logic [7:0]  st_o;
  logic        sf_o;
  logic        su_o;
  logic [20:0] rpc_o;
  logic        val_o;
  logic        rst_o;
  logic [7:0]  exp_st     = 8'h5c;
  logic        exp_sf     = 1'b0;
  logic        exp_su     = 1'b0;
  logic        exp_rst;
  logic        exp_val;
  logic        chk_pc;
  logic [20:0] exp_pc;
  logic [31:0] seed       = 32'd15099;
  int          mismatches = 0;
  int          checked    = 0;
  int          cycles     = 0;
  int          n_rst      = 0;
  int          n_val      = 0;
  power_mode_t modes [3]  = '{MODE_FULL, MODE_RUN, MODE_IDLE};

  always #2 clock_i = ~clock_i;

  reset_cause_flags reset_cause_flags_inst (
    .clock_i                    (clock_i),
    .sys_rst_i                  (sys_rst_i),
    .power_on_i                 (ev_r[0]),
    .brownout_i                 (ev_r[1]),
    .reset_instr_i              (ev_r[2]),
    .external_reset_pin_i       (ev_r[3]),
    .watchdog_i                 (ev_r[4]),
    .stack_full_i               (ev_r[5]),
    .stack_underflow_i          (ev_r[6]),
    .irq_wake_i                 (ev_r[7]),
    .power_mode_i               (mode_r),
    .stack_fault_reset_enable_i (stk_en_r),
    .brownout_mode_cfg_i        (cfg_r),
    .high_priority_irq_enable_i (hi_r),
    .low_priority_irq_enable_i  (lo_r),
    .current_pc_i               (pc_r),
    .sw_write_i                 (wr_r),
    .sw_wdata_i                 (wd_r),
    .reset_control_status_reg_o (st_o),
    .stack_full_flag_o          (sf_o),
    .stack_underflow_flag_o     (su_o),
    .restart_pc_o               (rpc_o),
    .restart_valid_o            (val_o),
    .core_reset_o               (rst_o)
  );

  // ----------------------------------------------------------------
  // Pulse counters and hang guard
  // ----------------------------------------------------------------
  // Pulses last one cycle, so they are counted every edge rather than sampled late.
  always @(posedge clock_i)
  begin
    n_rst = n_rst + ((rst_o === 1'b1) ? 1 : 0);
    n_val = n_val + ((val_o === 1'b1) ? 1 : 0);
    cycles = cycles + 1;
    if (cycles == LIMIT)
    begin
      mismatches = mismatches + 1;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Works out the flags, restart address and pulses for one event.
  function automatic void predict(input int e);
    logic idle;
    logic full;
    idle = (mode_r == MODE_IDLE);
    full = (mode_r == MODE_FULL);
    exp_rst = 1'b1;
    exp_val = 1'b1;
    chk_pc = 1'b1;
    exp_pc = 21'h000000;
    case (e)
      0: {exp_st, exp_sf, exp_su} = {8'h5c, 2'b00};
      1: {exp_st[4:2], exp_st[0]} = 4'b1110;
      2: exp_st[4] = 1'b0;
      3: if (!full) {exp_st[3], exp_st[2]} = {1'b1, !idle & exp_st[2]};
      4: if (idle) {exp_st[3:2], exp_rst, exp_pc} = {3'b000, pc_r + 21'h000002};
         else exp_st[3] = 1'b0;
      5: exp_sf = 1'b1;
      6: {exp_su, exp_rst, exp_val, chk_pc} = {1'b1, {3{stk_en_r}}};
      default: if (full) {exp_rst, exp_val, chk_pc} = 3'b000;
        else {exp_st[2], exp_rst, exp_pc} = {2'b00, hi_r ? 21'h000008 :
          (lo_r ? 21'h000018 : pc_r + 21'h000002)};
    endcase
    if (exp_rst && e != 0)
      exp_st[7:6] = {1'b0, (cfg_r == 2'h1) & exp_st[6]};
  endfunction

  // Raises one event after random settings, then compares everything it touches.
  task automatic fire(input int e, input power_mode_t m);
    logic [31:0] r;
    int          r0;
    int          v0;
    @(posedge clock_i);
    r = xs();
    mode_r <= m;
    cfg_r <= r[1:0];
    hi_r <= r[2];
    lo_r <= r[3];
    stk_en_r <= r[4] | (e == 5);
    pc_r <= r[25:5];
    r0 = n_rst;
    v0 = n_val;
    @(posedge clock_i);
    ev_r[e] <= 1'b1;
    repeat (3) @(posedge clock_i);
    ev_r[e] <= 1'b0;
    repeat (6) @(posedge clock_i);
    #1;
    predict(e);
    check(st_o, exp_st);
    check({sf_o, su_o}, {exp_sf, exp_su});
    check(n_rst - r0, exp_rst);
    check(n_val - v0, exp_val);
    if (chk_pc) check(rpc_o, exp_pc);
  endtask

  task automatic write(input logic [7:0] d);
    @(posedge clock_i);
    wr_r <= 1'b1;
    wd_r <= d;
    @(posedge clock_i);
    wr_r <= 1'b0;
    @(posedge clock_i);
    #1;
    exp_st = {d[7:6], 1'b0, d[4], exp_st[3:2], d[1:0]};
    check(st_o, exp_st);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    repeat (8) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    #1;
    check(st_o, 8'h5c);
    check({sf_o, su_o, rpc_o, val_o, rst_o}, 32'h0);
    for (int e = 0; e < 8; e++)
      for (int m = 0; m < 3; m++)
        fire(e, modes[m]);
    for (int i = 0; i < 100; i++)
    begin
      r = xs();
      if (r[0])
        write(r[15:8]);
      fire(int'(r[18:16]), modes[int'(r[21:20]) % 3]);
    end
    stop_test();
  end
endmodule
